// ### bench/evf_link_model.sv
// Far-side model: vector table reads and interrupt acknowledge.
`timescale 1ns/1ps
module evf_link_model (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        vec_rd_req,
	input  wire logic [31:0] vec_rd_addr,
	input  wire logic        interrupt_acknowledge_cycle,
	input  wire logic [2:0]  int_ack_level,
	output logic             vec_rd_valid,
	output logic [31:0]      vec_rd_data,
	output logic             int_ack_valid,
	output logic [7:0]       int_ack_vector
);
	logic [7:0] cnt;
	// Answers alternate between prompt and slow, and idle data keeps moving
	// so that a stale word is never mistaken for an answer.
	wire go_rd  = vec_rd_req && !vec_rd_valid && cnt[0];
	wire go_ack = interrupt_acknowledge_cycle && !int_ack_valid && cnt[0];
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			cnt <= 8'h00;
			vec_rd_valid <= 1'b0;
			vec_rd_data <= 32'h0;
			int_ack_valid <= 1'b0;
			int_ack_vector <= 8'h00;
		end
		else
		begin
			cnt <= cnt + 8'h01;
			vec_rd_valid <= go_rd;
			vec_rd_data <= go_rd ? ~vec_rd_addr : {4{cnt}};
			int_ack_valid <= go_ack;
			int_ack_vector <= go_ack ? {5'h08, int_ack_level} : cnt;
		end
endmodule : evf_link_model

// ### bench/tb_exception_vector_frame_unit.sv
// Self-checking bench for the exception vector and frame unit.
`timescale 1ns/1ps
module tb_exception_vector_frame_unit;
	import evf_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
	logic insn_boundary, exc_req, flow_valid, idx_valid, word_index_register;
	logic idx_full, fetch_bus_err, flow_change, insn_uses_fetch;
	logic oper_read_err, write_bus_err, write_prot_err, nop_exec;
	logic writes_pending, int_ack_valid, vec_rd_valid, vec_rd_req, init_done;
	logic interrupt_acknowledge_cycle, exc_start, abort_insn, handler_go;
	logic nop_stall, int_sample_en, av;
	logic [1:0] htrans, idx_scale;
	logic [2:0] hsize, int_level, int_ack_level;
	logic [3:0] trap_num;
	logic [7:0] int_ack_vector;
	logic [15:0] processor_status_word, new_status_word;
	logic [31:0] haddr, hwdata, hrdata, cur_pc, next_pc, stack_pointer_reg;
	logic [31:0] flow_target, vec_rd_data, vec_rd_addr, init_sp, init_pc;
	logic [31:0] frame_word0, frame_word1, frame_sp, handler_pc;
	logic [31:0] s = 32'h7205ADBE;
	logic [112:0] e;
	logic [112:0] q[$];
	logic ab = 1'b0;
	evf_class_t exc_class;
	int errors;
	int compares;
	assign hready = hreadyout;
	evf_top dut (.*);
	evf_link_model peer (.*);
	initial
	begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_of_test();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	// ****************************************************************
	// Bus master and exception causes
	// ****************************************************************
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] x);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		if (!w) check(hrdata, x);
		check({31'h0, hresp}, 32'h0);
		hsel <= 1'b0;
	endtask : ahb
	task automatic fire(input int k);
		logic [7:0] v;
		logic [3:0] f;
		logic [2:0] l;
		logic [15:0] p;
		s = lfsr(s);
		l = s[2:0] | 3'h1;
		p = {s[15:11], 3'h0, s[7:0]};
		v = (k < 4) ? VEC_ADDRESS : VEC_ACCESS;
		if (k == 8) v = VEC_TRAP_BASE + {4'h0, s[3:0]};
		if (k == 9) v = av ? VEC_AUTO_BASE + {5'h0, l} : {5'h08, l};
		if (k == 10) v = VEC_LINEF;
		f = (k == 4) ? FLT_READ : (k == 5) ? FLT_FETCH : FLT_NONE;
		f = (k == 6) ? FLT_WRITE : (k == 7) ? FLT_WPROT : f;
		@(posedge hclk);
		stack_pointer_reg <= s;
		cur_pc <= {s[15:0], s[31:16]};
		next_pc <= ~s;
		processor_status_word <= p;
		flow_valid <= k == 0;
		flow_target <= {s[31:1], 1'b1};
		idx_valid <= k inside {[1:3]};
		idx_full <= k == 1;
		word_index_register <= k == 2;
		idx_scale <= (k == 3) ? IDX_SCALE8 : 2'h0;
		oper_read_err <= k == 4;
		fetch_bus_err <= k == 5;
		write_bus_err <= k == 6;
		write_prot_err <= k == 7;
		exc_req <= k == 8 || k == 10;
		exc_class <= (k == 10) ? EVF_C_LINEF : EVF_C_TRAP;
		trap_num <= s[3:0];
		int_level <= (k == 9) ? l : 3'h0;
		q.push_back({k < 8 || k == 10, 4'h4 + {2'h0, s[1:0]}, f[3:2], v,
			f[1:0], p, (k inside {8, 9}) ? ~s : {s[15:0], s[31:16]},
			s - 32'h8 - {30'h0, s[1:0]},
			1'b0, p[14], 1'b1, p[12] & (k != 9), p[11],
			(k == 9) ? l : p[10:8], p[7:0]});
		@(posedge hclk);
		{flow_valid, idx_valid, oper_read_err, fetch_bus_err} <= '0;
		{write_bus_err, write_prot_err, exc_req} <= '0;
		insn_boundary <= k != 7;
		nop_exec <= k == 7;
		writes_pending <= k == 7;
		insn_uses_fetch <= k == 5;
		@(posedge hclk);
		insn_boundary <= 1'b0;
		insn_uses_fetch <= 1'b0;
		writes_pending <= 1'b0;
		@(posedge hclk);
		check({31'h0, nop_stall}, {31'h0, k == 7});
		for (int i = 0; i < 40 && handler_go !== 1'b1; i++) @(posedge hclk);
		check(handler_pc, ~{22'h0, v, 2'h0});
		check({31'h0, int_sample_en}, 32'h0);
		int_level <= 3'h0;
		nop_exec <= 1'b0;
		@(posedge hclk);
		insn_boundary <= 1'b1;
		@(posedge hclk);
		insn_boundary <= 1'b0;
		repeat (3) @(posedge hclk);
	endtask : fire
	always @(posedge hclk)
	begin
		if (abort_insn === 1'b1)
			ab = 1'b1;
		if (exc_start === 1'b1)
		begin
			e = q.pop_front();
			check({31'h0, ab}, {31'h0, e[112]});
			ab = 1'b0;
			check(frame_word0, e[111:80]);
			check(frame_word1, e[79:48]);
			check(frame_sp, e[47:16]);
			check({16'h0, new_status_word}, {16'h0, e[15:0]});
		end
	end
	initial
	begin
		#60000;
		errors++;
		end_of_test();
	end
	initial
	begin
		{hsel, hwrite, insn_boundary, exc_req, flow_valid, idx_valid, av,
			word_index_register, idx_full, fetch_bus_err, flow_change,
			insn_uses_fetch, oper_read_err, write_bus_err, write_prot_err,
			nop_exec, writes_pending, hresetn} = '0;
		{haddr, hwdata, cur_pc, next_pc, stack_pointer_reg, flow_target,
			htrans, idx_scale, hsize, int_level, trap_num} = '0;
		processor_status_word = 16'h0;
		exc_class = EVF_C_TRAP;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 40 && init_done !== 1'b1; i++) @(posedge hclk);
		check(init_sp, ~32'h0);
		check(init_pc, ~32'h4);
		for (int k = 0; k < 11; k++) fire(k);
		ahb(1'b1, 8'h40, s, 32'h0);
		ahb(1'b0, 8'h40, 32'h0, 32'h0);
		ahb(1'b1, OFS_EV_MASK, 32'hF, 32'h0);
		ahb(1'b0, OFS_EV_STATUS, 32'h0, 32'hF);
		check({31'h0, irq}, 32'h1);
		ahb(1'b1, OFS_EV_STATUS, 32'hF, 32'h0);
		repeat (3) @(posedge hclk);
		check({31'h0, irq}, 32'h0);
		ahb(1'b1, OFS_CTRL, 32'h1, 32'h0);
		av = 1'b1;
		fire(9);
		fire(8);
		repeat (5) @(posedge hclk);
		check(32'(q.size()), 32'h0);
		end_of_test();
	end
endmodule : tb_exception_vector_frame_unit

// ### verilog/evf_frame.sv
// Builds the two-longword exception stack frame.
`timescale 1ns/1ps
module evf_frame (
	evf_frame_if.builder fr
);
	import evf_pkg::*;

	wire [1:0]  sp_low = fr.stack_pointer_reg[1:0];
	wire [3:0]  format = FORMAT_BASE + {2'b00, sp_low};

	// The frame always lands on a longword boundary below the old pointer.
	assign fr.new_sp = fr.stack_pointer_reg - FRAME_BYTES
		- {30'h0000_0000, sp_low};
	assign fr.word0 = {format, fr.fault_status_field[3:2], fr.vector,
		fr.fault_status_field[1:0], fr.processor_status_word};
	assign fr.word1 = fr.pc;

endmodule : evf_frame

// ### verilog/evf_frame_if.sv
// Interface between the sequencer and the stack frame builder.
`timescale 1ns/1ps
interface evf_frame_if;
	logic [7:0]  vector;
	logic [3:0]  fault_status_field;
	logic [31:0] stack_pointer_reg;
	logic [15:0] processor_status_word;
	logic [31:0] pc;
	logic [31:0] word0;
	logic [31:0] word1;
	logic [31:0] new_sp;

	modport builder
	(
		input  vector,
		input  fault_status_field,
		input  stack_pointer_reg,
		input  processor_status_word,
		input  pc,
		output word0,
		output word1,
		output new_sp
	);

	modport user
	(
		output vector,
		output fault_status_field,
		output stack_pointer_reg,
		output processor_status_word,
		output pc,
		input  word0,
		input  word1,
		input  new_sp
	);
endinterface : evf_frame_if

// ### verilog/evf_pkg.sv
// Constants and types shared by the exception vector and frame unit.
package evf_pkg;

	// ****************************************************************
	// Vector numbers
	// ****************************************************************
	localparam logic [7:0] VEC_RESET_SP   = 8'h00;
	localparam logic [7:0] VEC_RESET_PC   = 8'h01;
	localparam logic [7:0] VEC_ACCESS     = 8'h02;
	localparam logic [7:0] VEC_ADDRESS    = 8'h03;
	localparam logic [7:0] VEC_ILLEGAL    = 8'h04;
	localparam logic [7:0] VEC_PRIV       = 8'h08;
	localparam logic [7:0] VEC_TRACE      = 8'h09;
	localparam logic [7:0] VEC_LINEA      = 8'h0A;
	localparam logic [7:0] VEC_LINEF      = 8'h0B;
	localparam logic [7:0] VEC_DEBUG      = 8'h0C;
	localparam logic [7:0] VEC_FORMAT     = 8'h0E;
	localparam logic [7:0] VEC_AUTO_BASE  = 8'h18;
	localparam logic [7:0] VEC_TRAP_BASE  = 8'h20;

	// ****************************************************************
	// Frame fields
	// ****************************************************************
	localparam logic [3:0] FLT_NONE       = 4'h0;
	localparam logic [3:0] FLT_FETCH      = 4'h4;
	localparam logic [3:0] FLT_WRITE      = 4'h8;
	localparam logic [3:0] FLT_WPROT      = 4'h9;
	localparam logic [3:0] FLT_READ       = 4'hC;
	localparam logic [3:0] FORMAT_BASE    = 4'h4;
	localparam logic [31:0] FRAME_BYTES   = 32'h0000_0008;
	localparam int         PSW_T          = 15;
	localparam int         PSW_S          = 13;
	localparam int         PSW_M          = 12;
	localparam int         TBASE_KEEP     = 12;
	localparam logic [1:0] IDX_SCALE8     = 2'h3;
	localparam logic [2:0] IPL_NMI        = 3'h7;
	localparam logic [31:0] RESET_PC_OFS  = 32'h0000_0004;

	// ****************************************************************
	// Register map and fields
	// ****************************************************************
	localparam logic [7:0] OFS_TBASE      = 8'h00;
	localparam logic [7:0] OFS_EV_STATUS  = 8'h04;
	localparam logic [7:0] OFS_EV_MASK    = 8'h08;
	localparam logic [7:0] OFS_CTRL       = 8'h0C;
	localparam logic [7:0] OFS_FRAME0     = 8'h10;
	localparam logic [7:0] OFS_FRAME1     = 8'h14;
	localparam logic [7:0] OFS_STATE      = 8'h18;
	localparam int         EV_W           = 4;
	localparam int         EV_EXC         = 0;
	localparam int         EV_ACCESS      = 1;
	localparam int         EV_ADDRESS     = 2;
	localparam int         EV_INT         = 3;
	localparam int         CTRL_AUTOVEC   = 0;
	localparam logic [11:0] TBASE_RESET   = 12'h000;

	typedef enum logic [2:0]
	{
		EVF_C_ILLEGAL,
		EVF_C_PRIV,
		EVF_C_LINEA,
		EVF_C_LINEF,
		EVF_C_FORMAT,
		EVF_C_TRACE,
		EVF_C_DEBUG,
		EVF_C_TRAP
	} evf_class_t;

	typedef enum logic [2:0]
	{
		S_RST_SP,
		S_RST_PC,
		S_IDLE,
		S_INT_ACK,
		S_FRAME,
		S_VEC,
		S_FIRST
	} evf_state_t;

endpackage : evf_pkg

// ### verilog/evf_top.sv
// Exception sequencer with vector selection, frame build and AHB registers.
// What this block does
// - Reset loads stack pointer from entry 0 and program counter from entry 1.
// - Access, address, illegal, privilege, line-a/f, format stack the faulting PC.
// - Trace, debug, interrupts and traps stack the next instruction's PC.
// - Autovectored levels one to seven use vectors 25 to 31.
// - Trap 0-15 use vectors 32-47; 64-255 are user interrupts.
// - No interrupt is sampled during a handler's first instruction.
// - Frame is format/vector word over status word, then the PC.
// - Format is four plus the pointer's low bits; pointer drops accordingly.
// - Fault status codes fetch 0100, write 1000/1001, read 1100, else zero.
// - Vector field is internal for faults and autovectored interrupts, acknowledged value for other interrupts.
// - A bus error termination raises an access error on vector two.
// - Fetch errors are tagged and raised only when an instruction uses them.
// - Operand read errors abort at once, keeping updates already done.
// - Write errors are reported imprecisely at the next instruction boundary or drained no-op.
// - A no-op stalls until buffered writes finish and reports their errors.
// - A control transfer to an odd target raises address error vector three.
// - Word index, scale eight or full-extension indexing raise address error.
// - Handler address is table base upper twelve bits plus four times vector.
// - Entry copies status, sets supervisor, clears trace; interrupts set mask.
`timescale 1ns/1ps
module evf_top (
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic                    hreadyout,
	output logic [31:0]             hrdata,
	output logic                    hresp,
	output logic                    irq,
	input  wire logic               insn_boundary,
	input  wire logic [31:0]        cur_pc,
	input  wire logic [31:0]        next_pc,
	input  wire logic [31:0]        stack_pointer_reg,
	input  wire logic [15:0]        processor_status_word,
	input  wire logic               exc_req,
	input  wire evf_pkg::evf_class_t exc_class,
	input  wire logic [3:0]         trap_num,
	input  wire logic               flow_valid,
	input  wire logic [31:0]        flow_target,
	input  wire logic               idx_valid,
	input  wire logic               word_index_register,
	input  wire logic [1:0]         idx_scale,
	input  wire logic               idx_full,
	input  wire logic               fetch_bus_err,
	input  wire logic               flow_change,
	input  wire logic               insn_uses_fetch,
	input  wire logic               oper_read_err,
	input  wire logic               write_bus_err,
	input  wire logic               write_prot_err,
	input  wire logic               nop_exec,
	input  wire logic               writes_pending,
	input  wire logic [2:0]         int_level,
	input  wire logic               int_ack_valid,
	input  wire logic [7:0]         int_ack_vector,
	input  wire logic               vec_rd_valid,
	input  wire logic [31:0]        vec_rd_data,
	output logic                    interrupt_acknowledge_cycle,
	output logic [2:0]              int_ack_level,
	output logic                    vec_rd_req,
	output logic [31:0]             vec_rd_addr,
	output logic                    init_done,
	output logic [31:0]             init_sp,
	output logic [31:0]             init_pc,
	output logic                    exc_start,
	output logic                    abort_insn,
	output logic [31:0]             frame_word0,
	output logic [31:0]             frame_word1,
	output logic [31:0]             frame_sp,
	output logic [15:0]             new_status_word,
	output logic                    handler_go,
	output logic [31:0]             handler_pc,
	output logic                    nop_stall,
	output logic                    int_sample_en
);
	import evf_pkg::*;

	// ****************************************************************
	// Cause detection and selection
	// ****************************************************************
	evf_state_t  state;
	evf_state_t  next_state;
	logic        fetch_tag;
	logic        wr_err_pend;
	logic [3:0]  wr_fstat;
	logic [11:0] vector_table_base;
	logic        ctrl_autovec;
	logic [7:0]  lat_vec;
	logic [3:0]  lat_fstat;
	logic [31:0] lat_pc;
	logic [31:0] lat_sp;
	logic [15:0] lat_psw;
	logic        lat_int;

	function automatic logic [7:0] class_vector(input evf_class_t c,
		input logic [3:0] n);
		case (c)
			EVF_C_ILLEGAL: class_vector = VEC_ILLEGAL;
			EVF_C_PRIV:    class_vector = VEC_PRIV;
			EVF_C_LINEA:   class_vector = VEC_LINEA;
			EVF_C_LINEF:   class_vector = VEC_LINEF;
			EVF_C_FORMAT:  class_vector = VEC_FORMAT;
			EVF_C_TRACE:   class_vector = VEC_TRACE;
			EVF_C_DEBUG:   class_vector = VEC_DEBUG;
			EVF_C_TRAP:    class_vector = VEC_TRAP_BASE + {4'h0, n};
			default:       class_vector = VEC_ILLEGAL;
		endcase
	endfunction : class_vector

	wire idx_bad     = idx_valid && (word_index_register
		|| idx_scale == IDX_SCALE8 || idx_full);
	wire addr_err    = (flow_valid && flow_target[0]) || idx_bad;
	wire fetch_fault = insn_uses_fetch && fetch_tag;
	wire read_fault  = oper_read_err;
	wire nop_drained = nop_exec && !writes_pending;
	wire write_fault = wr_err_pend
		&& (insn_boundary || nop_drained);
	wire access_err  = fetch_fault || read_fault || write_fault;
	wire may_take    = state == S_IDLE || state == S_FIRST;
	wire int_above   = int_level > processor_status_word[10:8]
		|| int_level == IPL_NMI;
	wire int_ok      = state == S_IDLE && insn_boundary
		&& int_level != 3'h0 && int_above;
	wire class_next  = exc_class == EVF_C_TRACE
		|| exc_class == EVF_C_DEBUG || exc_class == EVF_C_TRAP;
	wire any_cause   = addr_err || access_err || exc_req || int_ok;
	wire take        = may_take && any_cause;
	wire take_int    = !(addr_err || access_err || exc_req) && int_ok;
	wire take_trap   = !(addr_err || access_err) && exc_req
		&& exc_class == EVF_C_TRAP;
	wire need_int_ack = take_int && !ctrl_autovec;
	wire [7:0] auto_vec = VEC_AUTO_BASE + {5'h00, int_level};
	wire [7:0] sel_vec  = addr_err ? VEC_ADDRESS
		: access_err ? VEC_ACCESS
		: exc_req ? class_vector(exc_class, trap_num) : auto_vec;
	wire [3:0] sel_fstat = addr_err ? FLT_NONE
		: fetch_fault ? FLT_FETCH
		: read_fault ? FLT_READ
		: write_fault ? wr_fstat : FLT_NONE;
	wire sel_next       = !(addr_err || access_err)
		&& (exc_req ? class_next : 1'b1);
	wire [31:0] sel_pc  = sel_next ? next_pc : cur_pc;

	// ****************************************************************
	// Frame builder and entry status word
	// ****************************************************************
	evf_frame_if fr ();

	assign fr.vector                = lat_vec;
	assign fr.fault_status_field    = lat_fstat;
	assign fr.stack_pointer_reg     = lat_sp;
	assign fr.processor_status_word = lat_psw;
	assign fr.pc                    = lat_pc;

	evf_frame u_frame (
		.fr (fr.builder)
	);

	wire [15:0] entry_psw = {1'b0, lat_psw[14], 1'b1,
		lat_int ? 1'b0 : lat_psw[PSW_M], lat_psw[11],
		lat_int ? int_ack_level : lat_psw[10:8], lat_psw[7:0]};
	wire [31:0] table_base = {vector_table_base, 20'h00000};
	wire [31:0] handler_slot = table_base
		| {22'h000000, lat_vec, 2'b00};

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_comb
	begin
		next_state = state;
		case (state)
			S_RST_SP:
				if (vec_rd_valid)
					next_state = S_RST_PC;
			S_RST_PC:
				if (vec_rd_valid)
					next_state = S_IDLE;
			S_IDLE, S_FIRST:
				if (take)
					next_state = need_int_ack ? S_INT_ACK : S_FRAME;
				else if (state == S_FIRST && insn_boundary)
					next_state = S_IDLE;
			S_INT_ACK:
				if (int_ack_valid)
					next_state = S_FRAME;
			S_FRAME:
				next_state = S_VEC;
			S_VEC:
				if (vec_rd_valid)
					next_state = S_FIRST;
			default:
				next_state = S_RST_SP;
		endcase
	end

	wire next_rd = next_state == S_RST_SP || next_state == S_RST_PC
		|| next_state == S_VEC;
	wire [31:0] next_rd_addr = next_state == S_RST_SP ? table_base
		: next_state == S_RST_PC ? table_base + RESET_PC_OFS
		: handler_slot;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state                       <= S_RST_SP;
			vec_rd_req                  <= 1'b0;
			vec_rd_addr                 <= 32'h0000_0000;
			interrupt_acknowledge_cycle <= 1'b0;
			int_sample_en               <= 1'b0;
			exc_start                   <= 1'b0;
			abort_insn                  <= 1'b0;
			handler_go                  <= 1'b0;
			nop_stall                   <= 1'b0;
		end
		else
		begin
			state                       <= next_state;
			vec_rd_req                  <= next_rd;
			vec_rd_addr                 <= next_rd_addr;
			interrupt_acknowledge_cycle <= next_state == S_INT_ACK;
			int_sample_en               <= next_state == S_IDLE;
			exc_start                   <= state == S_FRAME;
			abort_insn                  <= take && !sel_next;
			handler_go                  <= state == S_VEC && vec_rd_valid;
			nop_stall                   <= nop_exec && writes_pending;
		end
	end

	// Cause details are frozen at the take so that the pipeline may move on.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			lat_vec       <= 8'h00;
			lat_fstat     <= 4'h0;
			lat_pc        <= 32'h0000_0000;
			lat_sp        <= 32'h0000_0000;
			lat_psw       <= 16'h0000;
			lat_int       <= 1'b0;
			int_ack_level <= 3'h0;
		end
		else if (take)
		begin
			lat_vec       <= sel_vec;
			lat_fstat     <= sel_fstat;
			lat_pc        <= sel_pc;
			lat_sp        <= stack_pointer_reg;
			lat_psw       <= processor_status_word;
			lat_int       <= take_int;
			int_ack_level <= int_level;
		end
		else if (state == S_INT_ACK && int_ack_valid)
			lat_vec       <= int_ack_vector;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			frame_word0     <= 32'h0000_0000;
			frame_word1     <= 32'h0000_0000;
			frame_sp        <= 32'h0000_0000;
			new_status_word <= 16'h0000;
			handler_pc      <= 32'h0000_0000;
		end
		else if (state == S_FRAME)
		begin
			frame_word0     <= fr.word0;
			frame_word1     <= fr.word1;
			frame_sp        <= fr.new_sp;
			new_status_word <= entry_psw;
		end
		else if (state == S_VEC && vec_rd_valid)
			handler_pc      <= vec_rd_data;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			init_sp   <= 32'h0000_0000;
			init_pc   <= 32'h0000_0000;
			init_done <= 1'b0;
		end
		else if (vec_rd_valid && state == S_RST_SP)
			init_sp   <= vec_rd_data;
		else if (vec_rd_valid && state == S_RST_PC)
		begin
			init_pc   <= vec_rd_data;
			init_done <= 1'b1;
		end
	end

	// A fetch error stays latent until used; a new setting beats the discard.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			fetch_tag   <= 1'b0;
			wr_err_pend <= 1'b0;
			wr_fstat    <= FLT_NONE;
		end
		else
		begin
			fetch_tag   <= fetch_bus_err
				|| (fetch_tag && !flow_change
				&& !(take && fetch_fault));
			wr_err_pend <= write_bus_err || write_prot_err
				|| (wr_err_pend && !(take && write_fault && !addr_err
				&& !fetch_fault && !read_fault));
			if (write_bus_err || write_prot_err)
				wr_fstat <= write_prot_err ? FLT_WPROT : FLT_WRITE;
		end
	end

	// ****************************************************************
	// AHB-Lite register slave
	// ****************************************************************
	// Reads are decoded in the address phase so data is ready with no wait.
	logic            wr_pend;
	logic [7:0]      wr_ofs;
	logic [EV_W-1:0] ev_status;
	logic [EV_W-1:0] ev_mask;

	wire        ahb_take  = hsel && hready && htrans[1];
	wire [7:0]  rd_ofs    = {haddr[7:2], 2'b00};
	wire        hit_tbase = wr_pend && wr_ofs == OFS_TBASE;
	wire        hit_stat  = wr_pend && wr_ofs == OFS_EV_STATUS;
	wire        hit_mask  = wr_pend && wr_ofs == OFS_EV_MASK;
	wire        hit_ctrl  = wr_pend && wr_ofs == OFS_CTRL;
	wire [EV_W-1:0] ev_set = {take && take_int,
		take && addr_err, take && !addr_err && access_err, take};
	wire [EV_W-1:0] ev_clr = hit_stat ? hwdata[EV_W-1:0] : '0;
	wire [31:0] rd_data =
		rd_ofs == OFS_TBASE ? {vector_table_base, 20'h00000}
		: rd_ofs == OFS_EV_STATUS ? {28'h0000000, ev_status}
		: rd_ofs == OFS_EV_MASK ? {28'h0000000, ev_mask}
		: rd_ofs == OFS_CTRL ? {31'h00000000, ctrl_autovec}
		: rd_ofs == OFS_FRAME0 ? frame_word0
		: rd_ofs == OFS_FRAME1 ? frame_word1
		: rd_ofs == OFS_STATE ? {29'h00000000, state}
		: 32'h0000_0000;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
			hrdata    <= 32'h0000_0000;
			wr_pend   <= 1'b0;
			wr_ofs    <= 8'h00;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend   <= ahb_take && hwrite;
			if (ahb_take)
				wr_ofs <= rd_ofs;
			if (ahb_take && !hwrite)
				hrdata <= rd_data;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			vector_table_base <= TBASE_RESET;
			ctrl_autovec      <= 1'b0;
			ev_mask           <= '0;
			ev_status         <= '0;
			irq               <= 1'b0;
		end
		else
		begin
			if (hit_tbase)
				vector_table_base <= hwdata[31:32-TBASE_KEEP];
			if (hit_ctrl)
				ctrl_autovec      <= hwdata[CTRL_AUTOVEC];
			if (hit_mask)
				ev_mask           <= hwdata[EV_W-1:0];
			// A new event beats a write-one-to-clear in the same cycle.
			ev_status <= (ev_status & ~ev_clr) | ev_set;
			irq       <= |(ev_status & ev_mask);
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_frame_out;
		##2 exc_start;
	endsequence

	chk_reset_vectors: assert property (
		$rose(init_done) |-> init_pc == $past(vec_rd_data)
			&& $past(vec_rd_addr) == table_base + RESET_PC_OFS)
		else $error("reset program counter not from entry one");
	chk_fault_pc: assert property (
		(take && addr_err) |-> s_frame_out
			##0 frame_word1 == $past(cur_pc, 2))
		else $error("address error did not stack faulting pc");
	chk_next_pc: assert property (
		(take && take_trap) |-> s_frame_out
			##0 frame_word1 == $past(next_pc, 2))
		else $error("trap did not stack next pc");
	chk_auto_vector: assert property (
		(take_int && ctrl_autovec) |-> s_frame_out
			##0 frame_word0[25:18] == 8'h18 + $past(int_level, 2))
		else $error("autovector number wrong");
	chk_trap_vector: assert property (
		(take && take_trap) |-> s_frame_out
			##0 frame_word0[25:18] == 8'h20 + $past(trap_num, 2))
		else $error("trap vector number wrong");
	chk_first_mask: assert property (
		(state == S_FIRST) |-> !(take && take_int) && !int_sample_en)
		else $error("interrupt sampled in first handler instruction");
	chk_frame_sp: assert property (
		(take && !need_int_ack) |-> s_frame_out
			##0 frame_sp == $past(stack_pointer_reg, 2)
			- 32'h8 - {30'h0, $past(stack_pointer_reg[1:0], 2)})
		else $error("frame stack pointer adjustment wrong");
	chk_nop_stall: assert property (
		(nop_exec && writes_pending) |=> nop_stall)
		else $error("no-op did not stall on pending writes");
	chk_handler_addr: assert property (
		exc_start |-> vec_rd_req && vec_rd_addr == (table_base
			| {22'h0, frame_word0[25:18], 2'b00}))
		else $error("handler vector address wrong");
	chk_entry_status: assert property (
		exc_start |-> !new_status_word[PSW_T] && new_status_word[PSW_S])
		else $error("entry status word not supervisor without trace");

endmodule : evf_top
